// ### verilog/cmr_consts.svh
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH

// register word indices (printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is four times it)
`define CMR_IDX_LANE0_PRE    14'h05C4
`define CMR_IDX_LANE1_PRE    14'h05C6
`define CMR_IDX_OFS_GLOBAL   14'h0701
`define CMR_IDX_OFS_LOCAL    14'h073B
`define CMR_IDX_DITHER       14'h0922
`define CMR_IDX_PLL_CAL      14'h1222
`define CMR_IDX_STARTUP      14'h1228
`define CMR_IDX_LOCK_CLR     14'h1262
`define CMR_IDX_VREF         14'h18A6
`define CMR_IDX_IRQ_STATUS   14'h1F00
`define CMR_IDX_IRQ_MASK     14'h1F01
`define CMR_IDX_STATE        14'h1F02

// reset values
`define CMR_RST_PRE          8'h00
`define CMR_RST_OFS_GLOBAL   8'h06
`define CMR_RST_OFS_LOCAL    8'hBF
`define CMR_RST_DITHER       8'h70
`define CMR_RST_PLL_CAL      8'h00
`define CMR_RST_STARTUP      8'h0F
`define CMR_RST_LOCK_CLR     8'h00
`define CMR_RST_VREF         8'h00

// codes
`define CMR_CODE_CAL_START   8'h04
`define CMR_CODE_NORMAL      8'h00
`define CMR_CODE_LOCK_CLEAR  8'h08
`define CMR_CODE_STARTUP_RST 8'h4F
`define CMR_CODE_OFS_ON      8'h86
`define CMR_CODE_OFS_OFF     8'h06
`define CMR_CODE_DITHER_ON   8'h70
`define CMR_CODE_DITHER_OFF  8'h71

// field positions
`define CMR_BIT_TOP          7
`define CMR_LVL_HI           6
`define CMR_LVL_LO           4
`define CMR_LVL_MAX          3'h4
`define CMR_LOCAL_RO         7'h3F
`define CMR_BIT_VREF         0
`define CMR_BIT_VREF_RW4     4

// interrupt status bits
`define CMR_IRQ_LOCK_LOST    0
`define CMR_IRQ_CAL_DONE     1
`define CMR_IRQ_OFS_MISMATCH 2
`define CMR_IRQ_W            3

// axi responses
`define CMR_RESP_OKAY        2'h0
`define CMR_RESP_SLVERR      2'h2

`endif

// ### verilog/cmr_pkg.sv
package cmr_pkg;
  typedef struct packed {
    logic       tapOn;
    logic [2:0] level;
  } cmr_pre_t;

  typedef struct packed {
    logic       lane0TapEnable;
    logic [3:0] lane0DbStep;
    logic       lane1TapPolarity;
    logic [3:0] lane1DbStep;
    logic       ditherEnable;
    logic       pllCalStart;
    logic       startupHold;
    logic       offsetCalGlobal;
    logic       offsetCalLocal;
    logic       externalRef;
  } cmr_ctrl_t;
endpackage : cmr_pkg

// ### verilog/cmr_misc_regs.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cmr_consts.svh"

module cmr_misc_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 pllLockLost,
  input  wire logic                 pllCalDone,
  output cmr_pkg::cmr_ctrl_t        ctrl,
  output logic                      lockLostLatched,
  output logic                      irq
);

  initial begin
    if (ADDR_W < 16) $error("ADDR_W must be at least 16");
  end

  logic [7:0] lane0Pre;
  logic [7:0] lane1Pre;
  logic [7:0] ofsGlobal;
  logic       ofsLocal;
  logic [7:0] dither;
  logic [7:0] pllCal;
  logic [7:0] startup;
  logic [7:0] lockClr;
  logic       vrefSel;
  logic       vrefRw4;
  logic [`CMR_IRQ_W-1:0] irqStatus;
  logic [`CMR_IRQ_W-1:0] irqMask;

  // write channel: address and data may arrive in either order
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [7:0]        wByte;
  logic              wLane0;
  logic              doWrite;
  logic              doRead;

  function automatic logic [13:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[15:2];
  endfunction : word_index

  // 0 dB plus 3 dB per step; codes above 4 are saturated to 12 dB
  function automatic logic [3:0] db_step(input logic [2:0] lvl);
    db_step = (lvl > `CMR_LVL_MAX) ? 4'hC : ({1'b0, lvl} * 4'h3);
  endfunction : db_step

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doRead        = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wHeld  <= 1'b0;
      wByte  <= 8'h00;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wByte  <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  logic [13:0] wIdx;
  logic        wHit;
  logic        we;
  assign wIdx = word_index(awAddr);
  always_comb begin
    case (wIdx)
      `CMR_IDX_LANE0_PRE, `CMR_IDX_LANE1_PRE, `CMR_IDX_OFS_GLOBAL,
      `CMR_IDX_OFS_LOCAL, `CMR_IDX_DITHER, `CMR_IDX_PLL_CAL,
      `CMR_IDX_STARTUP, `CMR_IDX_LOCK_CLR, `CMR_IDX_VREF,
      `CMR_IDX_IRQ_STATUS, `CMR_IDX_IRQ_MASK, `CMR_IDX_STATE:
        wHit = 1'b1;
      default: wHit = 1'b0;
    endcase
  end
  assign we = doWrite && wLane0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CMR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wHit ? `CMR_RESP_OKAY : `CMR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pre-emphasis: low nibble reserved, reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lane0Pre <= `CMR_RST_PRE;
      lane1Pre <= `CMR_RST_PRE;
    end else if (we && wIdx == `CMR_IDX_LANE0_PRE) begin
      lane0Pre <= {wByte[7:4], 4'h0};
    end else if (we && wIdx == `CMR_IDX_LANE1_PRE) begin
      lane1Pre <= {wByte[7:4], 4'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ofsGlobal <= `CMR_RST_OFS_GLOBAL;
      ofsLocal  <= 1'b1;
    end else if (we && wIdx == `CMR_IDX_OFS_GLOBAL) begin
      ofsGlobal <= wByte;
    end else if (we && wIdx == `CMR_IDX_OFS_LOCAL) begin
      ofsLocal <= wByte[`CMR_BIT_TOP];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dither <= `CMR_RST_DITHER;
    end else if (we && wIdx == `CMR_IDX_DITHER) begin
      dither <= wByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pllCal <= `CMR_RST_PLL_CAL;
    end else if (we && wIdx == `CMR_IDX_PLL_CAL) begin
      pllCal <= wByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startup <= `CMR_RST_STARTUP;
    end else if (we && wIdx == `CMR_IDX_STARTUP) begin
      startup <= wByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockClr <= `CMR_RST_LOCK_CLR;
    end else if (we && wIdx == `CMR_IDX_LOCK_CLR) begin
      lockClr <= wByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vrefSel <= 1'b0;
      vrefRw4 <= 1'b0;
    end else if (we && wIdx == `CMR_IDX_VREF) begin
      vrefSel <= wByte[`CMR_BIT_VREF];
      vrefRw4 <= wByte[`CMR_BIT_VREF_RW4];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqMask <= '0;
    end else if (we && wIdx == `CMR_IDX_IRQ_MASK) begin
      irqMask <= wByte[`CMR_IRQ_W-1:0];
    end
  end

  // loss-of-lock latch; a new loss in the clear cycle wins
  logic lockClrWrite;
  assign lockClrWrite = we && wIdx == `CMR_IDX_LOCK_CLR
                        && wByte == `CMR_CODE_LOCK_CLEAR;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockLostLatched <= 1'b0;
    end else if (pllLockLost) begin
      lockLostLatched <= 1'b1;
    end else if (lockClrWrite) begin
      lockLostLatched <= 1'b0;
    end
  end

  // the pairing is software's duty; a mismatch is only reported
  logic ofsMismatch;
  assign ofsMismatch = ofsGlobal[`CMR_BIT_TOP] == ofsLocal;

  logic [`CMR_IRQ_W-1:0] irqEvent;
  logic                  statusRead;
  assign irqEvent[`CMR_IRQ_LOCK_LOST]    = pllLockLost;
  assign irqEvent[`CMR_IRQ_CAL_DONE]     = pllCalDone;
  assign irqEvent[`CMR_IRQ_OFS_MISMATCH] = ofsMismatch;
  assign statusRead = doRead
                      && word_index(s_axi_araddr) == `CMR_IDX_IRQ_STATUS;

  // read clears; an event in the same cycle stays set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStatus <= '0;
    end else if (statusRead) begin
      irqStatus <= irqEvent;
    end else begin
      irqStatus <= irqStatus | irqEvent;
    end
  end

  assign irq = |(irqStatus & irqMask);

  logic [7:0] rdByte;
  logic       rdHit;
  always_comb begin
    rdHit  = 1'b1;
    rdByte = 8'h00;
    case (word_index(s_axi_araddr))
      `CMR_IDX_LANE0_PRE:  rdByte = lane0Pre;
      `CMR_IDX_LANE1_PRE:  rdByte = lane1Pre;
      `CMR_IDX_OFS_GLOBAL: rdByte = ofsGlobal;
      `CMR_IDX_OFS_LOCAL:  rdByte = {ofsLocal, `CMR_LOCAL_RO};
      `CMR_IDX_DITHER:     rdByte = dither;
      `CMR_IDX_PLL_CAL:    rdByte = pllCal;
      `CMR_IDX_STARTUP:    rdByte = startup;
      `CMR_IDX_LOCK_CLR:   rdByte = lockClr;
      `CMR_IDX_VREF:       rdByte = {3'h0, vrefRw4, 3'h0, vrefSel};
      `CMR_IDX_IRQ_STATUS: rdByte = {5'h00, irqStatus};
      `CMR_IDX_IRQ_MASK:   rdByte = {5'h00, irqMask};
      `CMR_IDX_STATE:      rdByte = {7'h00, lockLostLatched};
      default:             rdHit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CMR_RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rdByte};
      s_axi_rresp  <= rdHit ? `CMR_RESP_OKAY : `CMR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // decoded controls are registered so that the outputs come from flops
  cmr_pkg::cmr_pre_t pre0;
  cmr_pkg::cmr_pre_t pre1;
  assign pre0 = lane0Pre[7:4];
  assign pre1 = lane1Pre[7:4];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.lane0TapEnable   <= pre0.tapOn;
      ctrl.lane0DbStep      <= db_step(pre0.level);
      ctrl.lane1TapPolarity <= pre1.tapOn;
      ctrl.lane1DbStep      <= db_step(pre1.level);
      ctrl.ditherEnable     <= dither != `CMR_CODE_DITHER_OFF;
      ctrl.pllCalStart      <= pllCal == `CMR_CODE_CAL_START;
      ctrl.startupHold      <= startup == `CMR_CODE_STARTUP_RST;
      ctrl.offsetCalGlobal  <= ofsGlobal == `CMR_CODE_OFS_ON;
      ctrl.offsetCalLocal   <= !ofsLocal;
      ctrl.externalRef      <= vrefSel;
    end
  end

  property p_lock_clear;
    @(posedge clk) disable iff (!rst_n)
      lockClrWrite && !pllLockLost |=> !lockLostLatched;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("lock loss not cleared");

  sequence s_startup_write;
    we && wIdx == `CMR_IDX_STARTUP && wByte == `CMR_CODE_STARTUP_RST;
  endsequence
  property p_startup_hold;
    @(posedge clk) disable iff (!rst_n)
      s_startup_write ##1 1'b1 |=> ctrl.startupHold;
  endproperty
  a_startup_hold: assert property (p_startup_hold)
    else $error("startup hold not asserted");

  property p_ofs_on;
    @(posedge clk) disable iff (!rst_n)
      we && wIdx == `CMR_IDX_OFS_GLOBAL && wByte == `CMR_CODE_OFS_ON
      |=> ##1 ctrl.offsetCalGlobal;
  endproperty
  a_ofs_on: assert property (p_ofs_on)
    else $error("offset calibration not enabled");

  property p_cal_start;
    @(posedge clk) disable iff (!rst_n)
      ctrl.pllCalStart |-> $past(pllCal) == `CMR_CODE_CAL_START;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration start without code");
  // ctrl sits at zero for one cycle after reset, before the decode catches up
  property p_dither_off;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && !ctrl.ditherEnable
      |-> $past(dither) == `CMR_CODE_DITHER_OFF;
  endproperty
  a_dither_off: assert property (p_dither_off)
    else $error("dither off without code");
  property p_lane0_db;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> ctrl.lane0DbStep ==
        (($past(lane0Pre[`CMR_LVL_HI:`CMR_LVL_LO]) > `CMR_LVL_MAX) ? 4'hC
         : 4'(3 * $past(lane0Pre[`CMR_LVL_HI:`CMR_LVL_LO])));
  endproperty
  a_lane0_db: assert property (p_lane0_db)
    else $error("lane 0 level step wrong");
  property p_lane1_reserved;
    @(posedge clk) disable iff (!rst_n)
      lane1Pre[3:0] == 4'h0 && lane0Pre[3:0] == 4'h0;
  endproperty
  a_lane1_reserved: assert property (p_lane1_reserved)
    else $error("reserved pre-emphasis bits set");

  property p_lock_sticky;
    @(posedge clk) disable iff (!rst_n)
      pllLockLost |=> lockLostLatched;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("loss of lock not latched");

endmodule : cmr_misc_regs

// ### tb/cmr_misc_regs_bench.sv
`timescale 1ns/1ps
`include "cmr_consts.svh"
module cmr_misc_regs_bench;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [15:0]        awAddr = '0;
  logic [15:0]        arAddr = '0;
  logic [31:0]        wData = '0;
  logic               awValid = 1'b0;
  logic               wValid = 1'b0;
  logic               bReady = 1'b0;
  logic               arValid = 1'b0;
  logic               rReady = 1'b0;
  logic               lockLost = 1'b0;
  logic               calDone = 1'b0;
  logic [3:0]         wStrb = 4'hF;
  int                 loss[4] = '{2, 7, 12, 20};
  logic               awReady, wReady, bValid, arReady, rValid;
  logic               lockLostLatched, irq, seen;
  logic [1:0]         bResp, rResp;
  logic [31:0]        rData;
  cmr_pkg::cmr_ctrl_t ctrl;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 mdl[int], msk[int], rom[int];

  always #2.5 clk = ~clk;

  cmr_misc_regs #(.ADDR_W(16)) u_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .pllLockLost(lockLost),
    .pllCalDone(calDone), .ctrl(ctrl),
    .lockLostLatched(lockLostLatched), .irq(irq)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic timeout();
    error_cnt++;
    $display("MISMATCH t=%0t bus wait ran out", $time);
    end_of_test();
  endtask : timeout

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t rdata %h exp %h", $time, g, e);
    end
  endtask : chk32

  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t resp %h exp %h", $time, g, e);
    end
  endtask : chk_rsp

  task automatic chk_ctl(input logic [3:0] g, input int e);
    num_checks++;
    if (g !== 4'(e)) begin
      error_cnt++;
      $display("MISMATCH t=%0t output %h exp %0d", $time, g, e);
    end
  endtask : chk_ctl

  function automatic logic [1:0] exp_rsp(input int i);
    if (msk.exists(i) || i == `CMR_IDX_IRQ_STATUS || i == `CMR_IDX_STATE)
      return 2'h0;
    return 2'h2;
  endfunction : exp_rsp

  // software's choice of post-tap level for a channel loss, swing at 0
  function automatic int loss_code(input int db);
    if (db <= 4) return 0;
    if (db <= 9) return 1;
    if (db <= 14) return 2;
    return 3;
  endfunction : loss_code

  task automatic wr(input int i, input int d);
    logic a, w, b;
    int   n;
    a = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    awAddr  <= 16'(i * 4);
    wData   <= 32'(d);
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (b) begin
      @(posedge clk);
      if (a && awReady === 1'b1) a = 1'b0;
      if (w && wReady === 1'b1) w = 1'b0;
      if (!a && !w && bValid === 1'b1) begin
        chk_rsp(bResp, exp_rsp(i));
        b = 1'b0;
      end
      awValid <= a;
      wValid  <= w;
      bReady  <= b;
      n++;
      if (n > 200) timeout();
    end
    if (msk.exists(i) && wStrb[0]) mdl[i] = d & 'hFF;
    @(posedge clk);
  endtask : wr

  task automatic rdx(input int i, input int e);
    int n;
    n = 0;
    arAddr  <= 16'(i * 4);
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge clk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      n++;
      if (n > 200) timeout();
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    chk32(rData, 32'(e));
    chk_rsp(rResp, exp_rsp(i));
    @(posedge clk);
  endtask : rdx

  task automatic rd(input int i);
    rdx(i, (mdl[i] & msk[i]) | rom[i]);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  task automatic add(input int i, input int v, input int m, input int r);
    mdl[i] = v;
    msk[i] = m;
    rom[i] = r;
  endtask : add

  // only bits the registers keep are modelled; reserved bits read fixed
  task automatic rst_chk();
    add(`CMR_IDX_LANE0_PRE, 'h00, 'hF0, 0);
    add(`CMR_IDX_LANE1_PRE, 'h00, 'hF0, 0);
    add(`CMR_IDX_OFS_GLOBAL, 'h06, 'hFF, 0);
    add(`CMR_IDX_OFS_LOCAL, 'h80, 'h80, 'h3F);
    add(`CMR_IDX_DITHER, 'h70, 'hFF, 0);
    add(`CMR_IDX_PLL_CAL, 'h00, 'hFF, 0);
    add(`CMR_IDX_STARTUP, 'h0F, 'hFF, 0);
    add(`CMR_IDX_LOCK_CLR, 'h00, 'hFF, 0);
    add(`CMR_IDX_VREF, 'h00, 'h11, 0);
    add(`CMR_IDX_IRQ_MASK, 'h00, 'h07, 0);
    foreach (mdl[k]) rd(k);
    rdx(`CMR_IDX_IRQ_STATUS, 0);
    rdx(`CMR_IDX_STATE, 0);
    chk_ctl(4'(ctrl.ditherEnable), 1);
    chk_ctl(4'(ctrl.startupHold), 0);
  endtask : rst_chk

  initial begin
    void'($urandom(32'hF117));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rst_chk();
    for (int c = 0; c < 8; c++) begin
      wr(`CMR_IDX_LANE0_PRE, 'h80 | (c << 4) | ($urandom() & 15));
      settle();
      chk_ctl(ctrl.lane0DbStep, (c > 4) ? 12 : 3 * c);
      chk_ctl(4'(ctrl.lane0TapEnable), 1);
      rd(`CMR_IDX_LANE0_PRE);
    end
    for (int c = 0; c < 5; c++) begin
      wr(`CMR_IDX_LANE1_PRE, ((c & 1) << 7) | (c << 4) | 'hF);
      settle();
      chk_ctl(ctrl.lane1DbStep, 3 * c);
      chk_ctl(4'(ctrl.lane1TapPolarity), c & 1);
      rd(`CMR_IDX_LANE1_PRE);
    end
    foreach (loss[j]) begin
      int code;
      code = loss_code(loss[j]);
      wr(`CMR_IDX_LANE0_PRE, ((j & 1) << 7) | (code << 4));
      settle();
      chk_ctl(ctrl.lane0DbStep, 3 * code);
      chk_ctl(4'(ctrl.lane0TapEnable), j & 1);
      rd(`CMR_IDX_LANE0_PRE);
    end
    wr(`CMR_IDX_STARTUP, 'h4F);
    repeat (8) @(posedge clk);
    chk_ctl(4'(ctrl.startupHold), 1);
    wr(`CMR_IDX_STARTUP, 'h0F);
    settle();
    chk_ctl(4'(ctrl.startupHold), 0);
    for (int k = 0; k < 2; k++) begin
      wr(`CMR_IDX_DITHER, 'h71 - k);
      settle();
      chk_ctl(4'(ctrl.ditherEnable), k);
    end
    // a write with byte 0 disabled must leave the register alone
    wStrb <= 4'h0;
    wr(`CMR_IDX_DITHER, 'h71);
    wStrb <= 4'hF;
    settle();
    chk_ctl(4'(ctrl.ditherEnable), 1);
    rd(`CMR_IDX_DITHER);
    wr(`CMR_IDX_PLL_CAL, 'h04);
    seen = 1'b0;
    // start stays high until the code is cleared; look over a short span for it
    repeat (4) begin
      @(posedge clk);
      seen = seen | ctrl.pllCalStart;
    end
    chk_ctl(4'(seen), 1);
    wr(`CMR_IDX_PLL_CAL, 'h00);
    settle();
    chk_ctl(4'(ctrl.pllCalStart), 0);
    wr(`CMR_IDX_IRQ_MASK, 'h01);
    lockLost <= 1'b1;
    calDone  <= 1'b1;
    @(posedge clk);
    lockLost <= 1'b0;
    calDone  <= 1'b0;
    settle();
    chk_ctl(4'(lockLostLatched), 1);
    chk_ctl(4'(irq), 1);
    rdx(`CMR_IDX_STATE, 1);
    rdx(`CMR_IDX_IRQ_STATUS, 3);
    settle();
    chk_ctl(4'(irq), 0);
    rdx(`CMR_IDX_IRQ_STATUS, 0);
    calDone <= 1'b1;
    @(posedge clk);
    calDone <= 1'b0;
    settle();
    chk_ctl(4'(irq), 0);
    rdx(`CMR_IDX_IRQ_STATUS, 2);
    wr(`CMR_IDX_LOCK_CLR, 'h08);
    settle();
    chk_ctl(4'(lockLostLatched), 0);
    wr(`CMR_IDX_OFS_LOCAL, 'h00);
    wr(`CMR_IDX_OFS_GLOBAL, 'h86);
    settle();
    chk_ctl(4'(ctrl.offsetCalGlobal), 1);
    chk_ctl(4'(ctrl.offsetCalLocal), 1);
    rd(`CMR_IDX_OFS_LOCAL);
    // the pair is briefly mismatched between the two writes
    rdx(`CMR_IDX_IRQ_STATUS, 4);
    wr(`CMR_IDX_OFS_GLOBAL, 'h06);
    wr(`CMR_IDX_OFS_LOCAL, 'h80);
    settle();
    chk_ctl(4'(ctrl.offsetCalGlobal), 0);
    chk_ctl(4'(ctrl.offsetCalLocal), 0);
    rd(`CMR_IDX_OFS_GLOBAL);
    rdx(`CMR_IDX_IRQ_STATUS, 4);
    wr(`CMR_IDX_VREF, 'hFF);
    settle();
    chk_ctl(4'(ctrl.externalRef), 1);
    rd(`CMR_IDX_VREF);
    wr('h0010, 'h55);
    rdx('h0010, 0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rst_chk();
    end_of_test();
  end
endmodule : cmr_misc_regs_bench
